// file: src/sqad_match.sv
// Purpose: Tolerant pattern compare of a bit window against a pattern.
// Assumes: Combinational, caller registers the result.
// Notes: Match when mismatched bits do not exceed the tolerance.
`timescale 1ns/1ps
module sqad_match
   import sqad_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Compare operands
   input wire logic [WIDTH-1:0] i_window,
   input wire logic [WIDTH-1:0] i_pattern,
   input wire logic [3:0] i_tolerance,
   // Result
   output logic o_match
);

   localparam int CW = $clog2(WIDTH + 1);

   logic [WIDTH-1:0] diff;
   logic [CW-1:0] errors;

   // Per-bit mismatch
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_diff
         assign diff[g] = i_window[g] ^ i_pattern[g];
      end
   endgenerate

   // Mismatch count
   always_comb begin
      errors = '0;
      for (int k = 0; k < WIDTH; k++) begin
         errors = errors + CW'(diff[k]);
      end
   end

   // Widened so a 4-bit tolerance never wraps against a large count
   assign o_match = ({4'h0, errors} <= {{CW{1'b0}}, i_tolerance});

endmodule // sqad_match

// file: src/sqad_pkg.sv
// Purpose: Types shared by the sync qualifier files.
// Assumes: Constants live in sqad_regs.svh.
// Notes: Gray-coded search states.
package sqad_pkg;

   typedef logic [7:0] sqad_byte_t;

   // Diversity search states, Gray along idle, ant1, ant2, done
   typedef enum logic [1:0] {
      SQAD_IDLE = 2'h0,
      SQAD_MEAS1 = 2'h1,
      SQAD_MEAS2 = 2'h3,
      SQAD_DONE = 2'h2
   } sqad_div_state_t;

endpackage

// file: src/sqad_regs.svh
// Purpose: Register indices, field positions and reset values of the sync qualifier.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef SQAD_REGS_SVH
`define SQAD_REGS_SVH

// Register indices
`define SQAD_IDX_THRESH 8'h46
`define SQAD_IDX_TOLER 8'h47
`define SQAD_IDX_DIVCFG 8'h48
`define SQAD_IDX_DIVRES 8'h49
`define SQAD_IDX_ANT1ED 8'h4A
`define SQAD_IDX_ANT2ED 8'h4B
`define SQAD_IDX_OVRD 8'h4C
`define SQAD_IDX_IRQSTAT 8'h50
`define SQAD_IDX_IRQMASK 8'h51

// Tolerance fields
`define SQAD_SW_TOL_HI 7
`define SQAD_SW_TOL_LO 4
`define SQAD_PB_TOL_HI 3
`define SQAD_PB_TOL_LO 0

// Diversity config fields
`define SQAD_DIV_CTRL1 5
`define SQAD_DIV_CTRL0 4
`define SQAD_DIV_INV_ANT 3
`define SQAD_DIV_INV_TRX 2
`define SQAD_DIV_DPDT 1
`define SQAD_DIV_EN 0
`define SQAD_DIVCFG_MASK 8'h3F

// Diversity result fields
`define SQAD_RES_DONE 7
`define SQAD_RES_RSV_MASK 8'h7C
`define SQAD_RES_ANT1 2'h1
`define SQAD_RES_ANT2 2'h2

// Antenna override fields
`define SQAD_OVR_RECEIVE_ANTENNA_CHOICE 5
`define SQAD_OVR_RX_EN 4
`define SQAD_OVR_TRANSMIT_ANTENNA_CHOICE 1
`define SQAD_OVR_TX_EN 0
`define SQAD_OVRD_MASK 8'h33

// Interrupt bits
`define SQAD_IRQ_SYNC 0
`define SQAD_IRQ_DIV 1
`define SQAD_IRQ_REFUSE 2
`define SQAD_IRQ_MASK 8'h07

// Reset values
`define SQAD_RST_BYTE 8'h00
`define SQAD_RST_RESULT 2'h1

`endif

// file: src/sqad_top.sv
// Purpose: Sync qualification and antenna diversity with an APB register bank.
// Assumes: Demodulated bits and energy samples arrive synchronous to i_clock.
// Notes: All state freezes while i_clock_en is low, the APB slave included.
`timescale 1ns/1ps
`include "sqad_regs.svh"
module sqad_top
   import sqad_pkg::*;
#(
   parameter int SYNC_BITS = 32,
   parameter int PREAMBLE_BITS = 16,
   parameter int MEAS_SAMPLES = 4,
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Receiver side
   input wire logic i_rx_on,
   input wire logic i_tx_on,
   input wire logic i_rx_bit_valid,
   input wire logic i_rx_bit,
   input wire logic [SYNC_BITS-1:0] i_sync_pattern,
   input wire logic i_energy_valid,
   input wire logic [7:0] i_energy,
   input wire logic i_sync_energy_check_enable,
   // Sync and antenna outputs
   output logic o_sync_detected,
   output logic o_antenna_select_output,
   output logic o_antenna_select_output_b,
   output logic o_txrx_switch_output,
   output logic o_txrx_switch_output_b,
   output logic o_irq
);

   localparam int SCW = $clog2(MEAS_SAMPLES + 1);

   // Registers
   sqad_byte_t sync_energy_threshold;
   sqad_byte_t sync_error_tolerance;
   sqad_byte_t diversity_config;
   logic [4:0] result_reserved;
   logic diversity_search_done;
   logic [1:0] diversity_selected_antenna;
   sqad_byte_t first_antenna_energy_value;
   sqad_byte_t second_antenna_energy_value;
   sqad_byte_t antenna_override;
   sqad_byte_t irq_status;
   sqad_byte_t irq_mask;
   logic sync_energy_check_enable;

   // Receive datapath state
   logic [SYNC_BITS-1:0] shift_window;
   logic preamble_found;
   sqad_div_state_t div_state;
   logic [SCW-1:0] sample_count;
   sqad_byte_t meas_ant1;
   sqad_byte_t meas_ant2;
   logic candidate_ant2;
   logic rx_on_d;

   // APB decode
   wire apb_setup = i_psel & ~i_penable;
   wire apb_commit = i_psel & i_penable & o_pready;
   wire apb_wr = apb_commit & i_pwrite;
   wire aligned = (i_paddr[1:0] == 2'h0);
   wire [7:0] word_idx = 8'(i_paddr[ADDR_W-1:2]);
   wire hit_thresh = aligned & (word_idx == `SQAD_IDX_THRESH);
   wire hit_toler = aligned & (word_idx == `SQAD_IDX_TOLER);
   wire hit_divcfg = aligned & (word_idx == `SQAD_IDX_DIVCFG);
   wire hit_divres = aligned & (word_idx == `SQAD_IDX_DIVRES);
   wire hit_ant1 = aligned & (word_idx == `SQAD_IDX_ANT1ED);
   wire hit_ant2 = aligned & (word_idx == `SQAD_IDX_ANT2ED);
   wire hit_ovrd = aligned & (word_idx == `SQAD_IDX_OVRD);
   wire hit_stat = aligned & (word_idx == `SQAD_IDX_IRQSTAT);
   wire hit_mask = aligned & (word_idx == `SQAD_IDX_IRQMASK);
   wire hit_any = hit_thresh | hit_toler | hit_divcfg | hit_divres | hit_ant1 | hit_ant2
      | hit_ovrd | hit_stat | hit_mask;
   wire [7:0] wbyte = i_pwdata[7:0];

   // Configuration fields
   wire [3:0] syncword_error_tolerance =
      sync_error_tolerance[`SQAD_SW_TOL_HI:`SQAD_SW_TOL_LO];
   wire [3:0] preamble_error_tolerance =
      sync_error_tolerance[`SQAD_PB_TOL_HI:`SQAD_PB_TOL_LO];
   wire diversity_enable = diversity_config[`SQAD_DIV_EN];
   wire switch_type_select = diversity_config[`SQAD_DIV_DPDT];
   wire txrx_switch_polarity_invert = diversity_config[`SQAD_DIV_INV_TRX];
   wire antenna_select_polarity_invert = diversity_config[`SQAD_DIV_INV_ANT];
   wire receive_antenna_choice = antenna_override[`SQAD_OVR_RECEIVE_ANTENNA_CHOICE];
   wire receive_antenna_override_enable = antenna_override[`SQAD_OVR_RX_EN];
   wire transmit_antenna_choice = antenna_override[`SQAD_OVR_TRANSMIT_ANTENNA_CHOICE];
   wire transmit_antenna_override_enable = antenna_override[`SQAD_OVR_TX_EN];

   // Read mux
   wire [7:0] divres_read = {diversity_search_done, result_reserved,
      diversity_selected_antenna};
   wire [7:0] read_byte = hit_thresh ? sync_energy_threshold :
      hit_toler ? sync_error_tolerance :
      hit_divcfg ? diversity_config :
      hit_divres ? divres_read :
      hit_ant1 ? first_antenna_energy_value :
      hit_ant2 ? second_antenna_energy_value :
      hit_ovrd ? antenna_override :
      hit_stat ? irq_status :
      hit_mask ? irq_mask : `SQAD_RST_BYTE;

   // Bit window shift; new bit enters at the low end
   wire [SYNC_BITS-1:0] next_window = {shift_window[SYNC_BITS-2:0], i_rx_bit};

   // Preamble reference is an alternating pattern
   logic [PREAMBLE_BITS-1:0] preamble_ref;
   genvar g;
   generate
      for (g = 0; g < PREAMBLE_BITS; g++) begin : g_pref
         assign preamble_ref[g] = (g % 2 == 0) ? 1'b1 : 1'b0;
      end
   endgenerate

   logic preamble_hit;
   logic sync_hit;
   logic pre_match_a;
   logic pre_match_b;

   // Either phase of the alternation counts as preamble
   sqad_match #(.WIDTH(PREAMBLE_BITS)) u_pre_a (
      .i_window(next_window[PREAMBLE_BITS-1:0]),
      .i_pattern(preamble_ref),
      .i_tolerance(preamble_error_tolerance),
      .o_match(pre_match_a)
   );
   sqad_match #(.WIDTH(PREAMBLE_BITS)) u_pre_b (
      .i_window(next_window[PREAMBLE_BITS-1:0]),
      .i_pattern(~preamble_ref),
      .i_tolerance(preamble_error_tolerance),
      .o_match(pre_match_b)
   );
   sqad_match #(.WIDTH(SYNC_BITS)) u_sync (
      .i_window(next_window),
      .i_pattern(i_sync_pattern),
      .i_tolerance(syncword_error_tolerance),
      .o_match(sync_hit)
   );
   assign preamble_hit = pre_match_a | pre_match_b;

   // Sync qualification by energy
   wire sync_candidate = i_rx_on & i_rx_bit_valid & preamble_found & sync_hit;
   wire energy_ok = ~sync_energy_check_enable | (i_energy > sync_energy_threshold);
   wire sync_event = sync_candidate & energy_ok;
   wire refuse_event = sync_candidate & ~energy_ok;

   // Diversity search controls
   wire rx_start = i_rx_on & ~rx_on_d;
   wire sample_take = i_energy_valid & (sample_count == SCW'(MEAS_SAMPLES - 1));
   wire meas_done2 = (div_state == SQAD_MEAS2) & sample_take;
   wire next_cand_ant2 = (i_energy > meas_ant1);
   wire div_event = meas_done2;
   wire div_active = diversity_enable & i_rx_on;

   // Interrupt status: set wins over write-one-clear
   wire [7:0] irq_set = {5'h0, refuse_event, div_event, sync_event};
   wire [7:0] irq_clr = (apb_wr & hit_stat) ? wbyte : `SQAD_RST_BYTE;
   wire [7:0] next_irq_status = (irq_set | (irq_status & ~irq_clr)) & `SQAD_IRQ_MASK;
   wire div_flag_cleared = irq_clr[`SQAD_IRQ_DIV] & irq_status[`SQAD_IRQ_DIV]
      & ~div_event;

   // Antenna selection
   wire search_ant2 = (div_state == SQAD_MEAS2);
   wire div_ant2 = (div_state == SQAD_DONE) ? candidate_ant2 :
      (diversity_selected_antenna == `SQAD_RES_ANT2);
   wire auto_ant2 = div_active & ((div_state == SQAD_IDLE) ? div_ant2 :
      ((div_state == SQAD_DONE) ? candidate_ant2 : search_ant2));
   wire rx_ant2 = receive_antenna_override_enable ? receive_antenna_choice : auto_ant2;
   wire tx_ant2 = transmit_antenna_override_enable ? transmit_antenna_choice
      : (diversity_enable & div_ant2);
   wire use_ant2 = i_tx_on ? tx_ant2 : rx_ant2;
   wire next_ant_sel = use_ant2 ^ antenna_select_polarity_invert;
   wire next_trx_sel = i_tx_on ^ txrx_switch_polarity_invert;
   wire next_ant_sel_b = switch_type_select & ~next_ant_sel;
   wire next_trx_sel_b = switch_type_select & ~next_trx_sel;

   // APB answer: one wait-free access phase after setup
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else if (i_clock_en) begin
         o_pready <= apb_setup;
         o_prdata <= (apb_setup & ~i_pwrite) ? {24'h0, read_byte} : 32'h0;
         o_pslverr <= apb_setup & ~hit_any;
      end
   end

   // Software-written configuration
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_energy_threshold <= `SQAD_RST_BYTE;
         sync_error_tolerance <= `SQAD_RST_BYTE;
         diversity_config <= `SQAD_RST_BYTE;
         antenna_override <= `SQAD_RST_BYTE;
         irq_mask <= `SQAD_RST_BYTE;
         result_reserved <= 5'h0;
      end else if (i_clock_en) begin
         if (apb_wr & hit_thresh) begin
            sync_energy_threshold <= wbyte;
         end
         if (apb_wr & hit_toler) begin
            sync_error_tolerance <= wbyte;
         end
         if (apb_wr & hit_divcfg) begin
            diversity_config <= wbyte & `SQAD_DIVCFG_MASK;
         end
         if (apb_wr & hit_ovrd) begin
            antenna_override <= wbyte & `SQAD_OVRD_MASK;
         end
         if (apb_wr & hit_mask) begin
            irq_mask <= wbyte & `SQAD_IRQ_MASK;
         end
         if (apb_wr & hit_divres) begin
            result_reserved <= wbyte[6:2];
         end
      end
   end

   // Interrupt status and output
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_status <= `SQAD_RST_BYTE;
         o_irq <= 1'b0;
      end else if (i_clock_en) begin
         irq_status <= next_irq_status;
         o_irq <= |(next_irq_status & irq_mask);
      end
   end

   // Bit window and preamble tracking; a packet ends with receive off or sync
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shift_window <= '0;
         preamble_found <= 1'b0;
         rx_on_d <= 1'b0;
      end else if (i_clock_en) begin
         rx_on_d <= i_rx_on;
         if (~i_rx_on | sync_event) begin
            preamble_found <= 1'b0;
         end else if (i_rx_bit_valid & preamble_hit) begin
            preamble_found <= 1'b1;
         end
         if (i_rx_bit_valid) begin
            shift_window <= next_window;
         end
      end
   end

   // Diversity search: ant1 then ant2 over the preamble, keep the stronger
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_state <= SQAD_IDLE;
         sample_count <= '0;
         meas_ant1 <= `SQAD_RST_BYTE;
         meas_ant2 <= `SQAD_RST_BYTE;
         candidate_ant2 <= 1'b0;
         diversity_search_done <= 1'b0;
      end else if (i_clock_en) begin
         if (~div_active) begin
            div_state <= SQAD_IDLE;
            sample_count <= '0;
         end else begin
            unique case (div_state)
               SQAD_IDLE: begin
                  if (rx_start) begin
                     div_state <= SQAD_MEAS1;
                     sample_count <= '0;
                     diversity_search_done <= 1'b0;
                  end
               end
               SQAD_MEAS1: begin
                  if (i_energy_valid) begin
                     sample_count <= sample_take ? '0 : sample_count + SCW'(1);
                  end
                  if (sample_take) begin
                     meas_ant1 <= i_energy;
                     div_state <= SQAD_MEAS2;
                  end
               end
               SQAD_MEAS2: begin
                  if (i_energy_valid) begin
                     sample_count <= sample_take ? '0 : sample_count + SCW'(1);
                  end
                  if (sample_take) begin
                     meas_ant2 <= i_energy;
                     candidate_ant2 <= next_cand_ant2;
                     diversity_search_done <= 1'b1;
                     div_state <= SQAD_DONE;
                  end
               end
               SQAD_DONE: begin
                  // Held on the chosen antenna until sync word detection or receive end
                  if (sync_event) begin
                     div_state <= SQAD_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Results latched at sync word detection
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         diversity_selected_antenna <= `SQAD_RST_RESULT;
         first_antenna_energy_value <= `SQAD_RST_BYTE;
         second_antenna_energy_value <= `SQAD_RST_BYTE;
      end else if (i_clock_en) begin
         if (sync_event & diversity_enable) begin
            diversity_selected_antenna <= div_ant2 ? `SQAD_RES_ANT2 : `SQAD_RES_ANT1;
            first_antenna_energy_value <= meas_ant1;
            second_antenna_energy_value <= meas_ant2;
         end else if (div_flag_cleared) begin
            first_antenna_energy_value <= `SQAD_RST_BYTE;
            second_antenna_energy_value <= `SQAD_RST_BYTE;
         end else if (sync_event) begin
            diversity_selected_antenna <= `SQAD_RES_ANT1;
         end
      end
   end

   // Energy check enable pin latched so the check tracks a stable level
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_energy_check_enable <= 1'b0;
      end else if (i_clock_en) begin
         sync_energy_check_enable <= i_sync_energy_check_enable;
      end
   end

   // Registered pin drive
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_sync_detected <= 1'b0;
         o_antenna_select_output <= 1'b0;
         o_antenna_select_output_b <= 1'b0;
         o_txrx_switch_output <= 1'b0;
         o_txrx_switch_output_b <= 1'b0;
      end else if (i_clock_en) begin
         o_sync_detected <= sync_event;
         o_antenna_select_output <= next_ant_sel;
         o_antenna_select_output_b <= next_ant_sel_b;
         o_txrx_switch_output <= next_trx_sel;
         o_txrx_switch_output_b <= next_trx_sel_b;
      end
   end

endmodule // sqad_top

// file: test/sqad_chk.sv
// Purpose: Port-level assertions of the sync qualifier.
// Assumes: Sees only the top module ports, one clock domain.
// Notes: Bound into every sqad_top instance.
`timescale 1ns/1ps
module sqad_chk #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Radio side
   input wire logic i_rx_on,
   input wire logic i_tx_on,
   input wire logic o_sync_detected,
   input wire logic o_antenna_select_output,
   input wire logic o_antenna_select_output_b,
   input wire logic o_txrx_switch_output,
   input wire logic o_txrx_switch_output_b
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   // Setup phase, and a setup aimed at a misaligned word
   sequence s_setup;
      i_psel && !i_penable && i_clock_en;
   endsequence
   sequence s_misaligned;
      s_setup ##0 (i_paddr[1:0] != 2'h0);
   endsequence

   property p_ready;
      s_setup |=> o_pready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready missing after setup");
   property p_ready_once;
      o_pready && i_clock_en |=> !o_pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
   property p_misaligned;
      s_misaligned |=> (o_pready && o_pslverr);
   endproperty
   a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");
   property p_err_with_ready;
      o_pslverr |-> o_pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_data_quiet;
      !o_pready |-> (o_prdata == 32'h0) && (o_prdata[31:8] == 24'h0);
   endproperty
   a_data_quiet: assert property (p_data_quiet) else $error("read data outside access");
   property p_ant_pair;
      o_antenna_select_output_b |-> !o_antenna_select_output;
   endproperty
   a_ant_pair: assert property (p_ant_pair) else $error("antenna pair not complementary");
   property p_trx_pair;
      o_txrx_switch_output_b |-> !o_txrx_switch_output;
   endproperty
   a_trx_pair: assert property (p_trx_pair) else $error("switch pair not complementary");
   // Quiet bus keeps the invert bit still, so the switch must follow
   property p_trx_follow;
      ($changed(i_tx_on) && !i_psel && !$past(i_psel)) |=> $changed(o_txrx_switch_output);
   endproperty
   a_trx_follow: assert property (p_trx_follow) else $error("switch ignored transmit");
   property p_sync_rx;
      o_sync_detected |-> $past(i_rx_on);
   endproperty
   a_sync_rx: assert property (p_sync_rx) else $error("sync outside receive");
   c_sync: cover property (o_sync_detected);
endmodule // sqad_chk

bind sqad_top sqad_chk #(.ADDR_W(ADDR_W)) u_chk (.i_clock, .i_sys_rst, .i_clock_en,
   .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_rx_on, .i_tx_on,
   .o_sync_detected, .o_antenna_select_output, .o_antenna_select_output_b,
   .o_txrx_switch_output, .o_txrx_switch_output_b);

// file: test/sqad_src.sv
// Purpose: Front-end model feeding bits and antenna energy.
// Assumes: Energy follows the antenna the switch selects.
// Notes: Lines toggle between frames so stale values never look valid.
`timescale 1ns/1ps
module sqad_src (
   // Control
   input wire logic i_clock,
   input wire logic i_start,
   input wire logic [15:0] i_pflip,
   input wire logic [31:0] i_sflip,
   input wire logic [31:0] i_word,
   input wire logic [7:0] i_e1,
   input wire logic [7:0] i_e2,
   input wire logic i_ant,
   // Stream
   output logic o_valid,
   output logic o_bit,
   output logic [7:0] o_energy,
   output logic o_busy
);
   logic [47:0] frame;
   int cnt = 0;
   initial begin
      o_valid = 1'b0;
      o_bit = 1'b0;
      o_energy = 8'h00;
   end
   // Preamble then sync word, oldest first, one bit every other cycle
   always @(posedge i_clock) begin
      o_valid <= 1'b0;
      o_bit <= ~o_bit;
      o_energy <= ~o_energy;
      if (i_start) begin
         frame <= {16'hAAAA ^ i_pflip, i_word ^ i_sflip};
         cnt <= 96;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt % 2 == 0) begin
            o_valid <= 1'b1;
            o_bit <= frame[47];
            frame <= frame << 1;
            o_energy <= i_ant ? i_e2 : i_e1;
         end
      end
   end
   assign o_busy = (cnt != 0);
endmodule // sqad_src

// file: test/sqad_tb_top.sv
// Purpose: Self-checking bench of the sync qualifier over APB.
// Assumes: Stream model stands in for the demodulator and energy meter.
// Notes: Energy check enable is driven by the bench.
`timescale 1ns/1ps
`include "sqad_regs.svh"
module sqad_tb_top;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic rx_on = 1'b0, tx_on = 1'b0, start = 1'b0, sec = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rv, sflip = 32'h0;
   logic [15:0] pflip = 16'h0;
   logic [7:0] e1 = 8'h00, e2 = 8'h00, nrg;
   logic pready, pslverr, sync_det, ant, ant_b, trx, trx_b, irq, vld, bitv, busy, re;
   int err_total = 0, total_checks = 0, n_sync = 0, s0;
   localparam logic [31:0] WORD = 32'hB4C3_96E1;
   localparam logic [7:0] RWX [0:6] = '{8'hFF, 8'hFF, 8'h3F, 8'h7D, 8'h00, 8'h00, 8'h33};
   localparam logic [7:0] TOL [0:3] = '{8'h32, 8'h22, 8'h31, 8'h00};
   localparam logic [7:0] CFG [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h06, 8'h02};
   localparam logic [7:0] OVR [0:6] = '{8'h30, 8'h20, 8'h03, 8'h02, 8'h00, 8'h30, 8'h00};
   localparam logic [3:0] EXP [0:6] = '{4'h8, 4'h0, 4'hA, 4'h2, 4'h9, 4'hA, 4'h6};

   sqad_top DUT (.i_clock(clk), .i_sys_rst(rst), .i_clock_en(1'b1),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sync_energy_check_enable(sec),
      .i_rx_on(rx_on), .i_tx_on(tx_on), .i_rx_bit_valid(vld), .i_rx_bit(bitv),
      .i_sync_pattern(WORD), .i_energy_valid(vld), .i_energy(nrg),
      .o_sync_detected(sync_det), .o_antenna_select_output(ant),
      .o_antenna_select_output_b(ant_b), .o_txrx_switch_output(trx),
      .o_txrx_switch_output_b(trx_b), .o_irq(irq));
   sqad_src u_src (.i_clock(clk), .i_start(start), .i_pflip(pflip), .i_sflip(sflip),
      .i_word(WORD), .i_e1(e1), .i_e2(e2), .i_ant(ant), .o_valid(vld), .o_bit(bitv),
      .o_energy(nrg), .o_busy(busy));

   // Clock and reset
   initial forever #12.5 clk = ~clk;
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   end
   // Count sync pulses
   always @(posedge clk) if (sync_det === 1'b1) n_sync <= n_sync + 1;

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // One transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         err_total++;
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, ba(i), d);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] x, input string nm);
      apb(1'b0, ba(i), 8'h00);
      chk(nm, rv, {24'h0, x});
   endtask
   // One frame; peek reads the done bit while the search runs
   task automatic pkt(input logic [15:0] pf, input logic [31:0] sf, input logic [7:0] a1,
      input logic [7:0] a2, input logic peek);
      int n;
      n = 0;
      pflip <= pf;
      sflip <= sf;
      e1 <= a1;
      e2 <= a2;
      rx_on <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      if (peek) begin
         apb(1'b0, ba(`SQAD_IDX_DIVRES), 8'h00);
         chk("done during search", rv[7], 1'b0);
      end
      while (busy !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      rx_on <= 1'b0;
      @(posedge clk);
      if (n >= 300) begin
         err_total++;
         conclude();
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      // Reset values, then writable bits only
      for (int i = 0; i < 7; i++) rd(8'(`SQAD_IDX_THRESH + i), (i == 3) ? 8'h01 : 8'h00, "reset");
      rd(`SQAD_IDX_IRQMASK, 8'h00, "mask reset");
      for (int i = 0; i < 7; i++) wr(8'(`SQAD_IDX_THRESH + i), 8'hFF);
      for (int i = 0; i < 7; i++) rd(8'(`SQAD_IDX_THRESH + i), RWX[i], "access");
      for (int i = 0; i < 7; i++) wr(8'(`SQAD_IDX_THRESH + i), 8'h00);
      apb(1'b0, 12'h134, 8'h00);
      chk("unmapped error", {rv[7:0], re}, 9'h001);
      apb(1'b1, 12'h119, 8'hFF);
      chk("misaligned error", re, 1'b1);
      rd(`SQAD_IDX_THRESH, 8'h00, "misaligned write ignored");
      $display("test registers done");
      // Tolerance edges: pass, sync word one short, preamble one short, exact
      for (int i = 0; i < 4; i++) begin
         wr(`SQAD_IDX_TOLER, TOL[i]);
         s0 = n_sync;
         pkt((i == 3) ? 16'h0 : 16'h1008, (i == 3) ? 32'h0 : 32'h0100_8010, 8'h10, 8'h20, 1'b0);
         chk("sync count", n_sync - s0, (i == 0 || i == 3) ? 1 : 0);
      end
      rd(`SQAD_IDX_DIVRES, 8'h01, "single antenna result");
      rd(`SQAD_IDX_ANT1ED, 8'h00, "energy untouched");
      chk("irq masked", irq, 1'b0);
      wr(`SQAD_IDX_IRQMASK, 8'h01);
      @(posedge clk);
      chk("irq raised", irq, 1'b1);
      wr(`SQAD_IDX_IRQSTAT, 8'h01);
      @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      $display("test tolerance done");
      // Diversity picks the stronger antenna and latches both energies
      wr(`SQAD_IDX_DIVCFG, 8'h01);
      wr(`SQAD_IDX_IRQMASK, 8'h02);
      pkt(16'h0, 32'h0, 8'h20, 8'h50, 1'b0);
      rd(`SQAD_IDX_DIVRES, 8'h82, "result antenna two");
      rd(`SQAD_IDX_ANT1ED, 8'h20, "first energy");
      rd(`SQAD_IDX_ANT2ED, 8'h50, "second energy");
      chk("done irq", irq, 1'b1);
      wr(`SQAD_IDX_IRQSTAT, 8'h02);
      rd(`SQAD_IDX_ANT1ED, 8'h00, "first energy cleared");
      rd(`SQAD_IDX_ANT2ED, 8'h00, "second energy cleared");
      pkt(16'h0, 32'h0, 8'h60, 8'h30, 1'b1);
      rd(`SQAD_IDX_DIVRES, 8'h81, "result antenna one");
      rd(`SQAD_IDX_ANT1ED, 8'h60, "first energy again");
      rd(`SQAD_IDX_ANT2ED, 8'h30, "second energy again");
      wr(`SQAD_IDX_THRESH, 8'h60);
      for (int i = 0; i < 2; i++) begin
         wr(`SQAD_IDX_IRQSTAT, 8'h07);
         sec <= i[0];
         pkt(16'h0, 32'h0, 8'h60, 8'h30, 1'b0);
         rd(`SQAD_IDX_IRQSTAT, i ? 8'h06 : 8'h03, "energy check");
      end
      $display("test diversity done");
      // Overrides, polarity and switch type
      for (int i = 0; i < 7; i++) begin
         wr(`SQAD_IDX_DIVCFG, CFG[i]);
         wr(`SQAD_IDX_OVRD, OVR[i]);
         rx_on <= (i < 2 || i == 4 || i == 5);
         tx_on <= !(i < 2 || i == 4 || i == 5);
         repeat (3) @(posedge clk);
         chk("switch outputs", {ant, ant_b, trx, trx_b}, EXP[i]);
      end
      $display("test antenna control done");
      conclude();
   end
endmodule // sqad_tb_top
